// ---- hdl/edge_capture.sv ----
`timescale 1ns/1ps
`default_nettype none
module edge_capture #(
  parameter int W = 64
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin_i,
  input  wire logic [W-1:0] en_rise_i,
  input  wire logic [W-1:0] en_fall_i,
  output logic      [W-1:0] rise_evt_o,
  output logic      [W-1:0] fall_evt_o,
  output logic              wake_o
);
  logic [W-1:0] rise_tog;
  logic [W-1:0] fall_tog;
  logic [W-1:0] rise_s1_r, rise_s2_r, rise_s3_r;
  logic [W-1:0] fall_s1_r, fall_s2_r, fall_s3_r;

  initial begin
    if (W < 1) $error("edge_capture: W must be positive");
  end

  // Each pin clocks its own toggle flops, so edges are caught with MCLK stopped
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic rt_r;
    logic ft_r;
    always_ff @(posedge pin_i[i] or negedge rst_n) begin
      if (!rst_n) begin
        rt_r <= 1'b0;
      end else if (en_rise_i[i]) begin
        rt_r <= ~rt_r;
      end
    end
    always_ff @(negedge pin_i[i] or negedge rst_n) begin
      if (!rst_n) begin
        ft_r <= 1'b0;
      end else if (en_fall_i[i]) begin
        ft_r <= ~ft_r;
      end
    end
    assign rise_tog[i] = rt_r;
    assign fall_tog[i] = ft_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_s1_r <= '0;
      rise_s2_r <= '0;
      rise_s3_r <= '0;
      fall_s1_r <= '0;
      fall_s2_r <= '0;
      fall_s3_r <= '0;
    end else begin
      rise_s1_r <= rise_tog;
      rise_s2_r <= rise_s1_r;
      rise_s3_r <= rise_s2_r;
      fall_s1_r <= fall_tog;
      fall_s2_r <= fall_s1_r;
      fall_s3_r <= fall_s2_r;
    end
  end

  assign rise_evt_o = rise_s2_r ^ rise_s3_r;
  assign fall_evt_o = fall_s2_r ^ fall_s3_r;

  // Asynchronous level: high from the edge until the clock domain has seen it
  assign wake_o = |((rise_tog ^ rise_s3_r) | (fall_tog ^ fall_s3_r));
endmodule
`default_nettype wire

// ---- hdl/gpio_fast_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpio_fast_port #(
  parameter int NPORTS = gpio_pkg::NPORTS_DEF
) (
  // Clock and reset
  input  wire logic                        MCLK,
  input  wire logic                        RST_N,
  // AXI4-Lite write address
  input  wire logic [gpio_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic                        S_AXI_AWVALID,
  output logic                             S_AXI_AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0]                 S_AXI_WDATA,
  input  wire logic [3:0]                  S_AXI_WSTRB,
  input  wire logic                        S_AXI_WVALID,
  output logic                             S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0]                       S_AXI_BRESP,
  output logic                             S_AXI_BVALID,
  input  wire logic                        S_AXI_BREADY,
  // AXI4-Lite read address
  input  wire logic [gpio_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic                        S_AXI_ARVALID,
  output logic                             S_AXI_ARREADY,
  // AXI4-Lite read data
  output logic [31:0]                      S_AXI_RDATA,
  output logic [1:0]                       S_AXI_RRESP,
  output logic                             S_AXI_RVALID,
  input  wire logic                        S_AXI_RREADY,
  // Pins
  input  wire logic [NPORTS*32-1:0]        PIO_IN,
  output logic      [NPORTS*32-1:0]        PIO_OUT,
  output logic      [NPORTS*32-1:0]        PIO_OE,
  // Interrupt and wake
  output logic                             IRQ,
  output logic                             WAKE
);
  localparam int PB = gpio_pkg::PORT_BITS;
  localparam int EW = gpio_pkg::EDGE_PORTS * PB;

  initial begin
    if (NPORTS <= gpio_pkg::EDGE_PORT_B || NPORTS > 4) begin
      $error("gpio_fast_port: NPORTS must be 3 or 4");
    end
  end

  logic [31:0] dir_r  [NPORTS];
  logic [31:0] mask_r [NPORTS];
  logic [31:0] out_r  [NPORTS];
  logic [31:0] en_rise_r [gpio_pkg::EDGE_PORTS];
  logic [31:0] en_fall_r [gpio_pkg::EDGE_PORTS];
  logic [1:0]  int_mask_r;

  logic                        aw_full_r, w_full_r;
  logic [gpio_pkg::ADDR_W-1:0] aw_addr_r;
  logic [31:0]                 w_data_r;
  logic [3:0]                  w_strb_r;
  logic                        bvalid_r, rvalid_r;
  logic [1:0]                  bresp_r, rresp_r;
  logic [31:0]                 rdata_r;
  logic                        wr_fire, rd_fire;
  logic [31:0]                 be;
  logic                        wr_ok;
  logic [31:0]                 rdata_nxt;
  logic                        rd_ok;
  logic                        irq_r;

  logic [EW-1:0] edge_pins, en_rise_v, en_fall_v;
  logic [EW-1:0] rise_evt, fall_evt;
  logic [EW-1:0] st_rise, st_fall;
  logic [EW-1:0] clr_rise, clr_fall;

  // AXI4-Lite handshakes; address and data are taken in either order
  assign S_AXI_AWREADY = !aw_full_r;
  assign S_AXI_WREADY  = !w_full_r;
  assign S_AXI_ARREADY = !rvalid_r;
  assign S_AXI_BVALID  = bvalid_r;
  assign S_AXI_BRESP   = bresp_r;
  assign S_AXI_RVALID  = rvalid_r;
  assign S_AXI_RRESP   = rresp_r;
  assign S_AXI_RDATA   = rdata_r;

  assign wr_fire = aw_full_r && w_full_r && !bvalid_r;
  assign rd_fire = S_AXI_ARVALID && !rvalid_r;
  assign be      = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

  // Address decode helpers
  function automatic logic port_hit(input logic [7:0] a, input int p);
    port_hit = (a < gpio_pkg::EDGE_BASE) && (int'(a[6:5]) == p);
  endfunction

  function automatic logic edge_hit(input logic [7:0] a, input int e, input logic [3:0] off);
    edge_hit = (a[7:2] == 6'((gpio_pkg::EDGE_BASE + 8'(e) * gpio_pkg::EDGE_STRIDE + {4'h0, off}) >> 2));
  endfunction

  function automatic logic port_off_ok(input logic [4:0] o);
    port_off_ok = (o[4:2] == gpio_pkg::OFF_DIR[4:2]) || (o[4:2] == gpio_pkg::OFF_MASK[4:2]) ||
                  (o[4:2] == gpio_pkg::OFF_PIN[4:2]) || (o[4:2] == gpio_pkg::OFF_SET[4:2]) ||
                  (o[4:2] == gpio_pkg::OFF_CLR[4:2]);
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    if (a < gpio_pkg::EDGE_BASE) begin
      ok = (int'(a[6:5]) < NPORTS) && port_off_ok(a[4:0]);
    end else if (a < gpio_pkg::ADDR_INT_MASK) begin
      ok = 1'b1;
    end else if (a[7:2] == gpio_pkg::ADDR_INT_MASK[7:2] || a[7:2] == gpio_pkg::ADDR_INT_STAT[7:2]) begin
      ok = 1'b1;
    end
    addr_ok = ok;
  endfunction

  assign wr_ok = addr_ok(aw_addr_r);

  // Write channel capture and response
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= gpio_pkg::RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && !aw_full_r) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_full_r) begin
        w_full_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_full_r <= 1'b0;
        w_full_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_ok ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
      end else if (bvalid_r && S_AXI_BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Port direction, mask and output latch
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int p = 0; p < NPORTS; p++) begin
        dir_r[p]  <= gpio_pkg::RST_DIR;
        mask_r[p] <= gpio_pkg::RST_MASK;
        out_r[p]  <= gpio_pkg::RST_OUT;
      end
    end else if (wr_fire) begin
      for (int p = 0; p < NPORTS; p++) begin
        if (port_hit(aw_addr_r, p)) begin
          case (aw_addr_r[4:2])
            gpio_pkg::OFF_DIR[4:2]: begin
              dir_r[p] <= (dir_r[p] & ~be) | (w_data_r & be);
            end
            gpio_pkg::OFF_MASK[4:2]: begin
              mask_r[p] <= (mask_r[p] & ~be) | (w_data_r & be);
            end
            gpio_pkg::OFF_PIN[4:2]: begin
              // Whole-port load; masked bits and unstrobed lanes keep their value
              out_r[p] <= (out_r[p] & (mask_r[p] | ~be)) | (w_data_r & be & ~mask_r[p]);
            end
            gpio_pkg::OFF_SET[4:2]: begin
              out_r[p] <= out_r[p] | (w_data_r & be & ~mask_r[p]);
            end
            gpio_pkg::OFF_CLR[4:2]: begin
              out_r[p] <= out_r[p] & ~(w_data_r & be & ~mask_r[p]);
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // Edge enables and interrupt mask
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int e = 0; e < gpio_pkg::EDGE_PORTS; e++) begin
        en_rise_r[e] <= gpio_pkg::RST_EN;
        en_fall_r[e] <= gpio_pkg::RST_EN;
      end
      int_mask_r <= gpio_pkg::RST_INT_MASK;
    end else if (wr_fire) begin
      for (int e = 0; e < gpio_pkg::EDGE_PORTS; e++) begin
        if (edge_hit(aw_addr_r, e, gpio_pkg::OFF_EN_RISE)) begin
          en_rise_r[e] <= (en_rise_r[e] & ~be) | (w_data_r & be);
        end
        if (edge_hit(aw_addr_r, e, gpio_pkg::OFF_EN_FALL)) begin
          en_fall_r[e] <= (en_fall_r[e] & ~be) | (w_data_r & be);
        end
      end
      if (aw_addr_r[7:2] == gpio_pkg::ADDR_INT_MASK[7:2] && w_strb_r[0]) begin
        int_mask_r <= w_data_r[1:0];
      end
    end
  end

  // Edge capture on ports A and B
  assign edge_pins = {PIO_IN[gpio_pkg::EDGE_PORT_B*PB +: PB], PIO_IN[gpio_pkg::EDGE_PORT_A*PB +: PB]};
  assign en_rise_v = {en_rise_r[1], en_rise_r[0]};
  assign en_fall_v = {en_fall_r[1], en_fall_r[0]};

  edge_capture #(.W(EW)) u_edge (
    .clk        (MCLK),
    .rst_n      (RST_N),
    .pin_i      (edge_pins),
    .en_rise_i  (en_rise_v),
    .en_fall_i  (en_fall_v),
    .rise_evt_o (rise_evt),
    .fall_evt_o (fall_evt),
    .wake_o     (WAKE)
  );

  // Write-one-to-clear of the status words
  always_comb begin
    clr_rise = '0;
    clr_fall = '0;
    for (int e = 0; e < gpio_pkg::EDGE_PORTS; e++) begin
      if (wr_fire && edge_hit(aw_addr_r, e, gpio_pkg::OFF_ST_RISE)) begin
        clr_rise[e*PB +: PB] = w_data_r & be;
      end
      if (wr_fire && edge_hit(aw_addr_r, e, gpio_pkg::OFF_ST_FALL)) begin
        clr_fall[e*PB +: PB] = w_data_r & be;
      end
    end
  end

  sticky_flags #(.W(EW)) u_st_rise (
    .clk     (MCLK),
    .rst_n   (RST_N),
    .set_i   (rise_evt),
    .clr_i   (clr_rise),
    .flags_o (st_rise)
  );

  sticky_flags #(.W(EW)) u_st_fall (
    .clk     (MCLK),
    .rst_n   (RST_N),
    .set_i   (fall_evt),
    .clr_i   (clr_fall),
    .flags_o (st_fall)
  );

  // One summary bit per edge port, gated by the interrupt mask
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |({|(st_rise[PB +: PB] | st_fall[PB +: PB]),
                  |(st_rise[0 +: PB] | st_fall[0 +: PB])} & int_mask_r);
    end
  end
  assign IRQ = irq_r;

  // Read mux
  always_comb begin
    logic [7:0] a;
    a         = S_AXI_ARADDR;
    rdata_nxt = 32'h0000_0000;
    rd_ok     = addr_ok(a);
    for (int p = 0; p < NPORTS; p++) begin
      if (port_hit(a, p)) begin
        case (a[4:2])
          gpio_pkg::OFF_DIR[4:2]:  rdata_nxt = dir_r[p];
          gpio_pkg::OFF_MASK[4:2]: rdata_nxt = mask_r[p];
          gpio_pkg::OFF_PIN[4:2]:  rdata_nxt = PIO_IN[p*PB +: PB] & ~mask_r[p];
          gpio_pkg::OFF_SET[4:2]:  rdata_nxt = out_r[p] & ~mask_r[p];
          default:                 rdata_nxt = 32'h0000_0000;
        endcase
      end
    end
    for (int e = 0; e < gpio_pkg::EDGE_PORTS; e++) begin
      if (edge_hit(a, e, gpio_pkg::OFF_EN_RISE)) rdata_nxt = en_rise_r[e];
      if (edge_hit(a, e, gpio_pkg::OFF_EN_FALL)) rdata_nxt = en_fall_r[e];
      if (edge_hit(a, e, gpio_pkg::OFF_ST_RISE)) rdata_nxt = st_rise[e*PB +: PB];
      if (edge_hit(a, e, gpio_pkg::OFF_ST_FALL)) rdata_nxt = st_fall[e*PB +: PB];
    end
    if (a[7:2] == gpio_pkg::ADDR_INT_MASK[7:2]) rdata_nxt = {30'h0000_0000, int_mask_r};
    if (a[7:2] == gpio_pkg::ADDR_INT_STAT[7:2]) begin
      rdata_nxt = {30'h0000_0000, |(st_rise[PB +: PB] | st_fall[PB +: PB]), |(st_rise[0 +: PB] | st_fall[0 +: PB])};
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= gpio_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rd_ok ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
    end else if (rvalid_r && S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  // Pin drivers come straight from flops so all bits of a port change together
  always_comb begin
    for (int p = 0; p < NPORTS; p++) begin
      PIO_OUT[p*PB +: PB] = out_r[p];
      PIO_OE[p*PB +: PB]  = dir_r[p];
    end
  end
endmodule
`default_nettype wire

// ---- hdl/gpio_pkg.sv ----
package gpio_pkg;
  // Port bank geometry
  localparam int          PORT_BITS    = 32;
  localparam int          NPORTS_DEF   = 3;
  localparam int          ADDR_W       = 8;
  localparam int          EDGE_PORT_A  = 0;
  localparam int          EDGE_PORT_B  = 2;
  localparam int          EDGE_PORTS   = 2;

  // Per-port block: base = port * PORT_STRIDE
  localparam logic [7:0]  PORT_STRIDE  = 8'h20;
  localparam logic [4:0]  OFF_DIR      = 5'h00;
  localparam logic [4:0]  OFF_MASK     = 5'h10;
  localparam logic [4:0]  OFF_PIN      = 5'h14;
  localparam logic [4:0]  OFF_SET      = 5'h18;
  localparam logic [4:0]  OFF_CLR      = 5'h1C;

  // Edge blocks: port A at EDGE_BASE, port B at EDGE_BASE + EDGE_STRIDE
  localparam logic [7:0]  EDGE_BASE    = 8'h80;
  localparam logic [7:0]  EDGE_STRIDE  = 8'h10;
  localparam logic [3:0]  OFF_EN_RISE  = 4'h0;
  localparam logic [3:0]  OFF_EN_FALL  = 4'h4;
  localparam logic [3:0]  OFF_ST_RISE  = 4'h8;
  localparam logic [3:0]  OFF_ST_FALL  = 4'hC;

  localparam logic [7:0]  ADDR_INT_MASK = 8'hA0;
  localparam logic [7:0]  ADDR_INT_STAT = 8'hA4;

  // Reset values
  localparam logic [31:0] RST_DIR      = 32'h0000_0000;
  localparam logic [31:0] RST_MASK     = 32'h0000_0000;
  localparam logic [31:0] RST_OUT      = 32'h0000_0000;
  localparam logic [31:0] RST_EN       = 32'h0000_0000;
  localparam logic [1:0]  RST_INT_MASK = 2'h3;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage

// ---- hdl/sticky_flags.sv ----
`timescale 1ns/1ps
`default_nettype none
module sticky_flags #(
  parameter int W = 64
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  output logic      [W-1:0] flags_o
);
  initial begin
    if (W < 1) $error("sticky_flags: W must be positive");
  end

  // Set wins over a clear in the same cycle, so no event is lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_o <= '0;
    end else begin
      flags_o <= (flags_o & ~clr_i) | set_i;
    end
  end
endmodule
`default_nettype wire

// ---- verif/gpio_fast_port_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpio_fast_port_chk #(
  parameter int NPORTS = 3
) (
  // Clock and reset
  input wire logic                MCLK,
  input wire logic                RST_N,
  // Bus handshakes
  input wire logic                S_AXI_AWVALID,
  input wire logic                S_AXI_AWREADY,
  input wire logic                S_AXI_WVALID,
  input wire logic                S_AXI_WREADY,
  input wire logic [1:0]          S_AXI_BRESP,
  input wire logic                S_AXI_BVALID,
  input wire logic                S_AXI_BREADY,
  input wire logic                S_AXI_ARVALID,
  input wire logic                S_AXI_ARREADY,
  input wire logic [31:0]         S_AXI_RDATA,
  input wire logic                S_AXI_RVALID,
  input wire logic                S_AXI_RREADY,
  // Pins and events
  input wire logic [NPORTS*32-1:0] PIO_OUT,
  input wire logic [NPORTS*32-1:0] PIO_OE,
  input wire logic                IRQ,
  input wire logic                WAKE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // Wake must drop a few cycles after the edge is seen, else the chip never sleeps again
  logic [3:0] wk_r;
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) wk_r <= 4'h0;
    else wk_r <= WAKE ? wk_r + 4'(wk_r != 4'hF) : 4'h0;
  end
  a_rst_clean: assert property ($rose(RST_N) |-> PIO_OE == '0 && PIO_OUT == '0 && !IRQ)
    else $error("pins not idle after reset");
  a_oe_by_write: assert property ($changed(PIO_OE) |-> $rose(S_AXI_BVALID))
    else $error("direction moved without a write");
  a_out_by_write: assert property ($changed(PIO_OUT) |-> $rose(S_AXI_BVALID))
    else $error("output moved without a write");
  a_wr_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    && !S_AXI_BVALID |-> ##2 S_AXI_BVALID)
    else $error("write response late");
  a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  a_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read data late");
  a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  a_ar_refuse: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while busy");
  a_wake_short: assert property (wk_r < 4'h8)
    else $error("wake request stuck");
  c_write: cover property ($rose(S_AXI_BVALID));
  c_read: cover property ($rose(S_AXI_RVALID));
  c_irq: cover property ($rose(IRQ));
endmodule
bind gpio_fast_port gpio_fast_port_chk #(.NPORTS(NPORTS)) u_gpio_fast_port_chk (
  .MCLK          (MCLK),
  .RST_N         (RST_N),
  .S_AXI_AWVALID (S_AXI_AWVALID),
  .S_AXI_AWREADY (S_AXI_AWREADY),
  .S_AXI_WVALID  (S_AXI_WVALID),
  .S_AXI_WREADY  (S_AXI_WREADY),
  .S_AXI_BRESP   (S_AXI_BRESP),
  .S_AXI_BVALID  (S_AXI_BVALID),
  .S_AXI_BREADY  (S_AXI_BREADY),
  .S_AXI_ARVALID (S_AXI_ARVALID),
  .S_AXI_ARREADY (S_AXI_ARREADY),
  .S_AXI_RDATA   (S_AXI_RDATA),
  .S_AXI_RVALID  (S_AXI_RVALID),
  .S_AXI_RREADY  (S_AXI_RREADY),
  .PIO_OUT       (PIO_OUT),
  .PIO_OE        (PIO_OE),
  .IRQ           (IRQ),
  .WAKE          (WAKE)
);
`default_nettype wire

// ---- verif/pin_world.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_world #(
  parameter int W = 96
) (
  input wire logic [W-1:0] pio_out,
  input wire logic [W-1:0] pio_oe,
  input wire logic [W-1:0] ext,
  output logic     [W-1:0] pio_in
);
  // Driven bits loop back, undriven ones follow the outside world
  assign pio_in = (pio_oe & pio_out) | (~pio_oe & ext);
endmodule
`default_nettype wire

// ---- verif/test_fast_gpio_port_with_edge_wake.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module test_fast_gpio_port_with_edge_wake;
  logic        mclk = 0, rst_n = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0, b;
  logic [31:0] wdata = 0, rd_d, d, m, lf = 32'h0000_003D;
  logic [3:0]  wstrb = 0;
  logic [95:0] ext = 96'h0000_0020_0000_0000_0000_0000;
  wire  [95:0] pio_in, pio_out, pio_oe;
  wire  [31:0] rdata;
  wire  [1:0]  bresp, rresp;
  wire         awready, wready, bvalid, arready, rvalid, irq, wake;
  logic [31:0] dir_m [3], out_m [3];
  logic [1:0]  rsp;
  logic        wake_seen = 0;
  int          error_cnt = 0, samples_checked = 0;
  gpio_fast_port #(.NPORTS(3)) u_gpio_fast_port (.MCLK(mclk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PIO_IN(pio_in), .PIO_OUT(pio_out), .PIO_OE(pio_oe), .IRQ(irq), .WAKE(wake));
  pin_world #(.W(96)) u_pin_world (.pio_out(pio_out), .pio_oe(pio_oe), .ext(ext), .pio_in(pio_in));
  initial forever #50 mclk = ~mclk;
  always @(posedge wake) wake_seen = 1;
  function automatic logic [31:0] nx();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  task report_and_stop;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Handshakes are sampled mid-cycle, where they hold the value seen by the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] dv, input logic [3:0] s);
    bit ta, tw, tb;
    @(posedge mclk);
    awaddr <= a;
    wdata <= dv;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    tb = 0;
    for (int n = 0; n < 100 && !tb; n++) begin
      @(negedge mclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      rsp = bresp;
      @(posedge mclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      if (tb) bready <= 0;
    end
    if (!tb) begin
      error_cnt++;
      report_and_stop();
    end
  endtask
  task automatic rd(input logic [7:0] a);
    bit ta, tb;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    tb = 0;
    for (int n = 0; n < 100 && !tb; n++) begin
      @(negedge mclk);
      ta = arvalid && arready;
      tb = rvalid && rready;
      rd_d = rdata;
      rsp = rresp;
      @(posedge mclk);
      if (ta) arvalid <= 0;
      if (tb) rready <= 0;
    end
    if (!tb) begin
      error_cnt++;
      report_and_stop();
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(rd_d, e)
  endtask
  initial begin
    // A real falling reset edge clears the pin-clocked toggle flops, which MCLK never reaches
    rst_n <= 1'b0;
    repeat (12) @(posedge mclk);
    rst_n <= 1;
    `CHK(pio_oe, 96'h0)
    for (int p = 0; p < 3; p++) rc(8'(p * 32), 32'h0);
    rc(8'hA0, 32'h0000_0003);
    `CHK(rsp, gpio_pkg::RESP_OKAY)
    $display("test reset done");
    for (int p = 0; p < 3; p++) begin
      b = 8'(p * 32);
      dir_m[p] = nx();
      wr(b, dir_m[p], 4'hF);
      `CHK(rsp, gpio_pkg::RESP_OKAY)
      `CHK(pio_oe[p*32+:32], dir_m[p])
      d = nx();
      wr(b, d, 4'h4);
      dir_m[p][23:16] = d[23:16];
      rc(b, dir_m[p]);
      out_m[p] = nx();
      wr(b + 8'h14, out_m[p], 4'hF);
      `CHK(pio_out[p*32+:32], out_m[p])
      d = nx();
      wr(b + 8'h18, d, 4'hF);
      out_m[p] |= d;
      d = nx();
      wr(b + 8'h1C, d, 4'h3);
      out_m[p] &= ~(d & 32'h0000_FFFF);
      rc(b + 8'h18, out_m[p]);
      m = nx();
      wr(b + 8'h10, m, 4'hF);
      d = nx();
      wr(b + 8'h14, d, 4'hF);
      out_m[p] = (out_m[p] & m) | (d & ~m);
      d = nx();
      wr(b + 8'h18, d, 4'hF);
      out_m[p] |= d & ~m;
      `CHK(pio_out[p*32+:32], out_m[p])
      rc(b + 8'h18, out_m[p] & ~m);
      rc(b + 8'h14, ((dir_m[p] & out_m[p]) | (~dir_m[p] & ext[p*32+:32])) & ~m);
      rc(b + 8'h1C, 32'h0);
      wr(b, 32'h0, 4'hF);
      wr(b + 8'h10, 32'h0, 4'hF);
    end
    $display("test ports done");
    rc(8'hC0, 32'h0);
    `CHK(rsp, gpio_pkg::RESP_SLVERR)
    wr(8'h04, 32'hFFFF_FFFF, 4'hF);
    `CHK(rsp, gpio_pkg::RESP_SLVERR)
    rc(8'h00, 32'h0);
    $display("test errors done");
    wr(8'h80, 32'h0000_0008, 4'hF);
    ext[3] <= 1;
    repeat (6) @(posedge mclk);
    `CHK(irq, 1'b1)
    `CHK(wake_seen, 1'b1)
    rc(8'h88, 32'h0000_0008);
    rc(8'hA4, 32'h0000_0001);
    wr(8'hA0, 32'h0000_0002, 4'hF);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b0)
    wr(8'hA0, 32'h0000_0003, 4'hF);
    wr(8'h88, 32'h0000_0008, 4'hF);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b0)
    rc(8'h88, 32'h0);
    wr(8'h94, 32'h0000_0020, 4'hF);
    ext[69] <= 0;
    repeat (6) @(posedge mclk);
    rc(8'h9C, 32'h0000_0020);
    rc(8'h98, 32'h0);
    rc(8'hA4, 32'h0000_0002);
    `CHK(irq, 1'b1)
    // Both edges enabled on one pin: rising flag joins the pending falling flag
    wr(8'h90, 32'h0000_0020, 4'hF);
    ext[69] <= 1;
    repeat (6) @(posedge mclk);
    rc(8'h98, 32'h0000_0020);
    rc(8'h9C, 32'h0000_0020);
    wr(8'h98, 32'h0000_0020, 4'hF);
    wr(8'h9C, 32'h0000_0020, 4'h1);
    rc(8'hA4, 32'h0);
    `CHK(irq, 1'b0)
    wr(8'hA0, 32'h0, 4'hE);
    rc(8'hA0, 32'h0000_0003);
    $display("test edges done");
    report_and_stop();
  end
endmodule
`default_nettype wire
